// ===== logic/lusr_pkg.sv
package lusr_pkg;

  // clock and line timing
  localparam int unsigned LUSR_CLK_HZ     = 100_000_000;
  localparam int unsigned LUSR_BAUD       = 19_200;
  localparam int unsigned LUSR_BIT_CYCLES = LUSR_CLK_HZ / LUSR_BAUD;

  // header field lengths in bit times
  localparam int unsigned LUSR_BREAK_BITS   = 13;
  localparam int unsigned LUSR_DELIM_BITS   = 1;
  localparam int unsigned LUSR_BRK_DET_BITS = 11;
  localparam int unsigned LUSR_FRAME_BITS   = 10;

  // fixed values
  localparam logic [7:0] LUSR_SYNC_BYTE   = 8'h55;
  localparam logic [7:0] LUSR_ERR_CNT_RST = 8'h00;

  // one word from the dma controller
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } lusr_dma_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_BRK,
    ST_SYNC,
    ST_ID,
    ST_RESP_WAIT,
    ST_RESP
  } lusr_state_t;

endpackage

// ===== logic/lusr_tx_engine.sv
`timescale 1ns/1ps
module lusr_tx_engine
  import lusr_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = LUSR_BIT_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_start,
  input  wire logic       i_break,
  input  wire logic [7:0] i_byte,
  output logic            o_busy,
  output logic            o_done,
  output logic            o_txd
);

  localparam int TW = $clog2(BIT_CYCLES + 1);

  logic          busy_q;
  logic          brk_q;
  logic          done_q;
  logic [9:0]    shift_q;
  logic [4:0]    idx_q;
  logic [TW-1:0] tick_q;
  logic [4:0]    last_idx;
  logic          bit_end;

  assign last_idx = brk_q ? 5'(LUSR_BREAK_BITS + LUSR_DELIM_BITS - 1) : 5'(LUSR_FRAME_BITS - 1);
  assign bit_end  = (tick_q == TW'(BIT_CYCLES - 1));

  // bit timing and shifting, lsb first after a low start bit
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      busy_q  <= 1'b0;
      brk_q   <= 1'b0;
      shift_q <= 10'h3ff;
      idx_q   <= 5'h00;
      tick_q  <= '0;
    end else if (!busy_q && i_start) begin
      busy_q  <= 1'b1;
      brk_q   <= i_break;
      shift_q <= {1'b1, i_byte, 1'b0};
      idx_q   <= 5'h00;
      tick_q  <= '0;
    end else if (busy_q) begin
      if (bit_end) begin
        tick_q <= '0;
        if (idx_q == last_idx) begin
          busy_q <= 1'b0;
        end else begin
          idx_q   <= idx_q + 5'h01;
          shift_q <= {1'b1, shift_q[9:1]};
        end
      end else begin
        tick_q <= tick_q + TW'(1);
      end
    end
  end

  // one-cycle end of character
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= busy_q && bit_end && (idx_q == last_idx);
    end
  end

  // break is low for its bits, then high for the delimiter
  assign o_txd  = !busy_q ? 1'b1 : (brk_q ? (idx_q >= 5'(LUSR_BREAK_BITS)) : shift_q[0]);
  assign o_busy = busy_q;
  assign o_done = done_q;

endmodule

// ===== logic/lusr_lin_master.sv
// Functional notes
// - every read of the smart-card error counter returns zero
// - with dma mode select 0, first dma buffer slot is dropped, never sent
// - identifier write starts header once the dma transfer has data ready
// - identifier flag rises only for received headers, never for transmitted ones
// - with dma mode select 1, a started dma transfer never begins
`timescale 1ns/1ps
module lusr_lin_master
  import lusr_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = LUSR_BIT_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_lin_master_en,
  input  wire logic       i_lin_dma_mode_select,
  input  wire logic       i_lin_identifier_wr,
  input  wire logic [7:0] i_lin_frame_identifier,
  input  wire logic       i_dma_start,
  input  wire lusr_dma_t  i_dma,
  output logic            o_dma_ready,
  input  wire logic       i_smartcard_error_counter_rd,
  output logic [7:0]      o_smartcard_error_count,
  output logic            o_err_rd_valid,
  input  wire logic       i_lin_id_flag_clr,
  output logic            o_lin_id_flag,
  output logic [7:0]      o_rx_identifier,
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_frame_busy,
  output logic            o_frame_done
);

  localparam int CW = $clog2(LUSR_BREAK_BITS * BIT_CYCLES + 1);

  function automatic logic [CW-1:0] cyc(input int unsigned n);
    return CW'(n);
  endfunction

  lusr_state_t   state_q;
  logic          armed_q;
  logic          skip_q;
  logic          id_pend_q;
  logic [7:0]    id_q;
  logic          last_q;
  logic          done_q;
  logic [7:0]    err_cnt_q;
  logic          err_vld_q;
  logic          flag_q;
  logic [7:0]    rx_id_q;
  logic [CW-1:0] low_cnt_q;
  logic          hunt_q;
  logic          rx_act_q;
  logic [CW-1:0] rx_tick_q;
  logic [3:0]    rx_bit_q;
  logic [7:0]    rx_sh_q;
  logic          sync_ok_q;
  logic          tx_start;
  logic          tx_brk;
  logic [7:0]    tx_byte;
  logic          tx_busy;
  logic          tx_done;
  logic          go;
  logic          skip_pop;
  logic          resp_pop;
  logic          id_evt;

  lusr_tx_engine #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (tx_start),
    .i_break    (tx_brk),
    .i_byte     (tx_byte),
    .o_busy     (tx_busy),
    .o_done     (tx_done),
    .o_txd      (o_txd)
  );

  // header launch and byte sequencing
  assign skip_pop = armed_q && skip_q && i_dma.valid;
  assign go       = (state_q == ST_IDLE) && i_lin_master_en && id_pend_q && armed_q
                    && !skip_q && i_dma.valid;
  assign resp_pop = (state_q == ST_RESP_WAIT) && i_dma.valid && !tx_busy;

  always_comb begin
    tx_start = 1'b0;
    tx_brk   = 1'b0;
    tx_byte  = id_q;
    case (state_q)
      ST_IDLE: begin
        tx_start = go;
        tx_brk   = 1'b1;
      end
      ST_BRK: begin
        tx_start = tx_done;
        tx_byte  = LUSR_SYNC_BYTE;
      end
      ST_SYNC: begin
        tx_start = tx_done;
      end
      ST_RESP_WAIT: begin
        tx_start = resp_pop;
        tx_byte  = i_dma.data;
      end
      default: begin
        tx_start = 1'b0;
      end
    endcase
  end

  assign o_dma_ready  = skip_pop || resp_pop;
  assign o_frame_busy = (state_q != ST_IDLE);
  assign o_frame_done = done_q;

  // frame state machine
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      last_q  <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE: if (go) begin
          state_q <= ST_BRK;
        end
        ST_BRK: if (tx_done) begin
          state_q <= ST_SYNC;
        end
        ST_SYNC: if (tx_done) begin
          state_q <= ST_ID;
        end
        ST_ID: if (tx_done) begin
          state_q <= ST_RESP_WAIT;
        end
        ST_RESP_WAIT: if (resp_pop) begin
          state_q <= ST_RESP;
          last_q  <= i_dma.last;
        end
        ST_RESP: if (tx_done) begin
          state_q <= last_q ? ST_IDLE : ST_RESP_WAIT;
          done_q  <= last_q;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // dma arming, stale slot drop and identifier holding
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      armed_q   <= 1'b0;
      skip_q    <= 1'b0;
      id_pend_q <= 1'b0;
      id_q      <= 8'h00;
    end else begin
      if (state_q == ST_RESP && tx_done && last_q) begin
        armed_q <= 1'b0;
      end
      if (i_dma_start && i_lin_master_en && !i_lin_dma_mode_select) begin
        armed_q <= 1'b1;
        skip_q  <= 1'b1;
      end else if (skip_pop) begin
        skip_q  <= 1'b0;
      end
      if (i_lin_identifier_wr && i_lin_master_en) begin
        id_pend_q <= 1'b1;
        id_q      <= i_lin_frame_identifier;
      end else if (go) begin
        id_pend_q <= 1'b0;
      end
    end
  end

  // error counter reads always answer zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      err_cnt_q <= LUSR_ERR_CNT_RST;
      err_vld_q <= 1'b0;
    end else begin
      err_vld_q <= i_smartcard_error_counter_rd;
      err_cnt_q <= LUSR_ERR_CNT_RST;
    end
  end
  assign o_smartcard_error_count = err_cnt_q;
  assign o_err_rd_valid          = err_vld_q;

  // header receiver: break, sync, identifier; muted while transmitting
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      low_cnt_q <= '0;
      hunt_q    <= 1'b0;
      rx_act_q  <= 1'b0;
      rx_tick_q <= '0;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      sync_ok_q <= 1'b0;
    end else if (state_q != ST_IDLE) begin
      low_cnt_q <= '0;
      hunt_q    <= 1'b0;
      rx_act_q  <= 1'b0;
    end else begin
      if (!i_rxd) begin
        if (low_cnt_q != cyc(LUSR_BRK_DET_BITS * BIT_CYCLES)) begin
          low_cnt_q <= low_cnt_q + cyc(1);
        end
      end else begin
        low_cnt_q <= '0;
      end
      if (i_rxd && low_cnt_q == cyc(LUSR_BRK_DET_BITS * BIT_CYCLES)) begin
        hunt_q    <= 1'b1;
        sync_ok_q <= 1'b0;
        rx_act_q  <= 1'b0;
      end else if (hunt_q && !rx_act_q && !i_rxd) begin
        rx_act_q  <= 1'b1;
        rx_tick_q <= cyc(BIT_CYCLES / 2);
        rx_bit_q  <= 4'h0;
      end else if (rx_act_q) begin
        if (rx_tick_q == '0) begin
          rx_tick_q <= cyc(BIT_CYCLES - 1);
          rx_bit_q  <= rx_bit_q + 4'h1;
          if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
            rx_sh_q <= {i_rxd, rx_sh_q[7:1]};
          end
          if (rx_bit_q == 4'h9) begin
            rx_act_q <= 1'b0;
            if (!sync_ok_q && rx_sh_q == LUSR_SYNC_BYTE && i_rxd) begin
              sync_ok_q <= 1'b1;
            end else begin
              hunt_q <= 1'b0;
            end
          end
        end else begin
          rx_tick_q <= rx_tick_q - cyc(1);
        end
      end
    end
  end

  // identifier event only while no own frame is on the wire
  assign id_evt = (state_q == ST_IDLE) && rx_act_q && (rx_tick_q == '0) && (rx_bit_q == 4'h9)
                  && sync_ok_q && i_rxd;

  // identifier flag, a new header beats a clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flag_q  <= 1'b0;
      rx_id_q <= 8'h00;
    end else if (id_evt) begin
      flag_q  <= 1'b1;
      rx_id_q <= rx_sh_q;
    end else if (i_lin_id_flag_clr) begin
      flag_q  <= 1'b0;
    end
  end
  assign o_lin_id_flag   = flag_q;
  assign o_rx_identifier = rx_id_q;

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  chk_err_read_zero: assert property (
    i_smartcard_error_counter_rd |=> o_err_rd_valid && (o_smartcard_error_count == 8'h00))
    else $error("error counter read not zero");
  chk_stale_slot_drop: assert property (
    skip_pop |-> o_dma_ready && !tx_start ##1 !skip_q && (state_q == ST_IDLE || $past(state_q) != ST_IDLE))
    else $error("first dma slot not dropped");
  chk_header_launch: assert property (
    go |=> (state_q == ST_BRK) && tx_busy && !id_pend_q)
    else $error("header did not start");
  chk_break_low: assert property (
    (tx_start && tx_brk) |=> !o_txd [*8])
    else $error("break not driven low");
  chk_no_tx_flag: assert property (
    (state_q != ST_IDLE) && !flag_q |=> !flag_q)
    else $error("identifier flag raised by own header");
  chk_dma_blocked: assert property (
    (i_dma_start && i_lin_dma_mode_select && !armed_q) |=> !armed_q && !o_dma_ready)
    else $error("dma began with mode select set");
  chk_resp_from_dma: assert property (
    resp_pop |-> (tx_byte == i_dma.data) ##1 (state_q == ST_RESP) && tx_busy)
    else $error("response byte not taken from dma");

  cov_full_frame: cover property ($rose(o_frame_done));
  cov_header_rx:  cover property (id_evt);
  cov_flag_race:  cover property (id_evt && i_lin_id_flag_clr);

endmodule

// ===== dv/lusr_slave_model.sv
`timescale 1ns/1ps
module lusr_slave_model
  import lusr_pkg::*;
#(
  parameter int unsigned B = 16
) (
  input  wire logic i_core_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  logic [7:0] got_q [$];
  logic [9:0] v;
  // bus idles high through the pull-up
  initial o_rxd = 1'b1;
  // n bits onto the receive line, lsb first, one bit time each
  task automatic send_bits(input logic [15:0] c, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge i_core_clk);
      o_rxd = c[i];
      repeat (B - 1) @(negedge i_core_clk);
    end
  endtask
  // break of 13 bits plus delimiter, then sync and identifier
  task automatic send_hdr(input logic [7:0] id);
    send_bits(16'h2000, 14);
    send_bits({7'h01, LUSR_SYNC_BYTE, 1'b0}, 10);
    send_bits({7'h01, id, 1'b0}, 10);
  endtask
  // decodes characters on the transmit line, a break is skipped
  initial forever begin
    @(negedge i_core_clk);
    if (i_txd === 1'b0) begin
      repeat (B / 2) @(negedge i_core_clk);
      for (int i = 0; i < 10; i++) begin
        if (i > 0) repeat (B) @(negedge i_core_clk);
        v[i] = i_txd;
      end
      if (v[9] === 1'b1) got_q.push_back(v[8:1]);
      else while (i_txd !== 1'b1) @(negedge i_core_clk);
    end
  end
endmodule

// ===== dv/test_usart_lin_master_dma_quirks.sv
`timescale 1ns/1ps
module test_usart_lin_master_dma_quirks
  import lusr_pkg::*;
();
  localparam int unsigned B = 16;
  logic       clk, rst, en, sel, id_wr, dstart, err_rd, flag_clr;
  logic [7:0] id, cnt, rx_id;
  lusr_dma_t  dma;
  logic       rdy, erv, flag, rxd, txd, busy, done;
  int         miscompares, checks;
  logic [31:0] seed = 32'hfcc22e7a;

  lusr_lin_master #(.BIT_CYCLES(B)) u_dut (
    .i_core_clk(clk), .i_rst(rst), .i_lin_master_en(en), .i_lin_dma_mode_select(sel),
    .i_lin_identifier_wr(id_wr), .i_lin_frame_identifier(id), .i_dma_start(dstart), .i_dma(dma),
    .o_dma_ready(rdy), .i_smartcard_error_counter_rd(err_rd), .o_smartcard_error_count(cnt),
    .o_err_rd_valid(erv), .i_lin_id_flag_clr(flag_clr), .o_lin_id_flag(flag), .o_rx_identifier(rx_id),
    .i_rxd(rxd), .o_txd(txd), .o_frame_busy(busy), .o_frame_done(done)
  );
  lusr_slave_model #(.B(B)) slave (.i_core_clk(clk), .i_txd(txd), .o_rxd(rxd));

  // free running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic give_up(input string what);
    miscompares++;
    $display("timeout waiting for %s", what);
    give_verdict();
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one cycle strobe, raised and lowered on falling edges
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  task automatic wait_hi(ref logic s, input int n, input string what);
    int k;
    k = 0;
    while (s !== 1'b1) begin
      @(posedge clk);
      #1;
      k++;
      if (k > n) give_up(what);
    end
  endtask

  // dma word held until ready is seen at a rising edge
  task automatic offer(input logic l, input logic [7:0] d);
    int k;
    k = 0;
    @(negedge clk);
    dma = '{1'b1, l, d};
    do begin
      @(posedge clk);
      k++;
      if (k > 4000) give_up("dma ready");
    end while (rdy !== 1'b1);
    @(negedge clk);
    dma.valid = 1'b0;
  endtask

  // full master frame: stale slot, identifier, n response bytes
  task automatic frame(input bit early, input int n);
    logic [7:0] exp_q [$];
    logic [7:0] d;
    id = 8'(rnd());
    exp_q = '{LUSR_SYNC_BYTE, id};
    slave.got_q.delete();
    if (early) pulse(id_wr);
    pulse(dstart);
    offer(1'b0, ~id);
    if (!early) pulse(id_wr);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      exp_q.push_back(d);
      offer(i == n - 1, d);
      if (i == 0) check("busy in frame", {7'h00, busy}, 8'h01);
    end
    wait_hi(done, 30 * B, "frame done");
    check("busy after done", {7'h00, busy}, 8'h00);
    repeat (B) @(negedge clk);
    check("byte count", 8'(slave.got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) check("tx byte", slave.got_q[i], exp_q[i]);
    check("id flag after tx", {7'h00, flag}, 8'h00);
    $display("frame test done early %0d bytes %0d", early, n);
  endtask

  initial begin
    int k;
    {rst, en, sel, id_wr, dstart, err_rd, flag_clr} = 7'h40;
    id = 8'h00;
    dma = '0;
    en = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    check("txd idle", {7'h00, txd}, 8'h01);
    check("ready idle", {7'h00, rdy}, 8'h00);
    check("busy idle", {7'h00, busy}, 8'h00);
    // error counter reads at random spacing
    for (int i = 0; i < 4; i++) begin
      repeat (int'(rnd() & 32'h3)) @(negedge clk);
      pulse(err_rd);
      check("err valid", {7'h00, erv}, 8'h01);
      check("err count", cnt, LUSR_ERR_CNT_RST);
    end
    $display("error read test done");
    frame(1'b0, 1);
    frame(1'b0, 3);
    frame(1'b1, 2);
    // mode select set: a started transfer never takes a word
    @(negedge clk);
    sel = 1'b1;
    pulse(dstart);
    dma = '{1'b1, 1'b1, 8'(rnd())};
    pulse(id_wr);
    k = 0;
    repeat (300) begin
      @(posedge clk);
      if (rdy !== 1'b0 || txd !== 1'b1 || busy !== 1'b0) k++;
    end
    check("dma never begins", 8'(k), 8'h00);
    @(negedge clk);
    rst = 1'b1;
    sel = 1'b0;
    dma = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    $display("mode select test done");
    // header sent by a slave sets the flag
    id = 8'(rnd());
    slave.send_hdr(id);
    wait_hi(flag, 4 * B, "id flag");
    check("rx identifier", rx_id, id);
    pulse(flag_clr);
    check("flag cleared", {7'h00, flag}, 8'h00);
    $display("receive test done");
    give_verdict();
  end
endmodule
